// File: hw/sps_defs.svh
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// byte framing
`define SPS_BITS 4'h8
`define SPS_EDGES 5'h10

// rate divider codes and system clocks per half serial clock period
`define SPS_RATE_DIV4 2'h0
`define SPS_RATE_DIV8 2'h1
`define SPS_RATE_DIV16 2'h2
`define SPS_RATE_DIV64 2'h3
`define SPS_HALF_DIV4 6'h02
`define SPS_HALF_DIV8 6'h04
`define SPS_HALF_DIV16 6'h08
`define SPS_HALF_DIV64 6'h20

// reset values
`define SPS_DATA_RST 8'h00

`endif

// File: hw/sps_pkg.sv
`default_nettype none
package sps_pkg;

   // master sequencer
   typedef enum logic [0:0] {ST_IDLE, ST_RUN} sps_mst_e;

   // complete state of the port
   typedef struct packed {
      sps_mst_e mst;
      logic [5:0] hcnt;
      logic [4:0] ecnt;
      logic [3:0] bcnt;
      logic [7:0] sr;
      logic [7:0] rx;
      logic sclk_prev;
      logic sclk;
      logic sclk_oe;
      logic mosi;
      logic mosi_oe;
      logic miso_oe;
      logic done;
      logic write_collision_flag;
      logic ovf;
      logic irq;
      logic arm;
      logic busy;
   } sps_state_s;

endpackage
`default_nettype wire

// File: hw/sps_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "sps_defs.svh"

// Contract
// - slave ignores clock while select high
// - slave shifts with master clock when selected
// - phase bit chooses format; zero presents early
// - phase zero edge use per polarity
// - phase one edge use per polarity
// - master data write starts a transfer
// - master phase zero drives bit half early
// - master phase one drives bit first edge
// - bit order selects msb or lsb first
// - done flag set after last shift
// - slave phase zero write while selected collides
// - slave phase one write allowed when idle
// - received byte replaces sent byte in register
// - interrupt when done flag rises
// - write during transfer only sets collision
// - collision detection in master and slave
// - slave unread byte overwritten, overrun set
// - flags clear by status read then data access
// - master eight pulses, clock idles otherwise
// - rate field divides by 4,8,16,64
// - slave out driven only while enabled
module sps_port
(
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   // configuration
   input wire logic I_ENABLE,
   input wire logic I_MASTER_SELECT,
   input wire logic I_CPOL,
   input wire logic I_CPHA,
   input wire logic I_BIT_ORDER_SELECT,
   input wire logic [1:0] I_RATE_DIVIDER_SELECT,
   // software access strobes
   input wire logic I_DATA_WR,
   input wire logic [7:0] I_DATA_WDATA,
   input wire logic I_DATA_RD,
   input wire logic I_STATUS_RD,
   // software visible state
   output logic [7:0] O_DATA_RDATA,
   output logic O_TRANSFER_DONE_FLAG,
   output logic O_WRITE_COLLISION_FLAG,
   output logic O_RECEIVE_OVERRUN_FLAG,
   output logic O_SERIAL_DONE_IRQ,
   output logic O_BUSY,
   // serial clock pin
   input wire logic I_SCLK,
   output logic O_SCLK,
   output logic O_SCLK_OE,
   // master out pin
   input wire logic I_MOSI,
   output logic O_MOSI,
   output logic O_MOSI_OE,
   // slave out pin
   input wire logic I_MISO,
   output logic O_MISO,
   output logic O_MISO_OE,
   // slave select, active low
   input wire logic I_SS_N
);

   sps_pkg::sps_state_s st_q;
   sps_pkg::sps_state_s st_d;
   logic [5:0] half_len;
   logic slv_act;
   logic lead;
   logic trail;
   logic sample;
   logic shift_out;
   logic in_bit;
   logic [7:0] sr_shift;
   logic done_set;
   logic wr_ok;
   logic wr_col;

   // ----------------------------------------------------------------
   // edge decode
   // ----------------------------------------------------------------

   // half serial period in system clocks
   always_comb
   begin
      case (I_RATE_DIVIDER_SELECT)
         `SPS_RATE_DIV4: half_len = `SPS_HALF_DIV4;
         `SPS_RATE_DIV8: half_len = `SPS_HALF_DIV8;
         `SPS_RATE_DIV16: half_len = `SPS_HALF_DIV16;
         `SPS_RATE_DIV64: half_len = `SPS_HALF_DIV64;
         default: half_len = `SPS_HALF_DIV4;
      endcase
   end

   // leading edge leaves idle level, trailing edge returns to it
   always_comb
   begin
      slv_act = I_ENABLE && !I_MASTER_SELECT && !I_SS_N;
      lead = 1'b0;
      trail = 1'b0;
      if (slv_act)
      begin
         // slave follows the master's clock, no rate of its own
         lead = (st_q.sclk_prev == I_CPOL) && (I_SCLK != I_CPOL);
         trail = (st_q.sclk_prev != I_CPOL) && (I_SCLK == I_CPOL);
      end
      else if (I_MASTER_SELECT && st_q.mst == sps_pkg::ST_RUN && st_q.hcnt == half_len - 6'h01
               && st_q.ecnt != `SPS_EDGES)
      begin
         lead = (st_q.sclk == I_CPOL);
         trail = (st_q.sclk != I_CPOL);
      end
      // phase zero samples on leading edge, phase one on trailing
      sample = I_CPHA ? trail : lead;
      shift_out = I_CPHA ? lead : trail;
   end

   // received bit enters at the end opposite the outgoing one
   assign in_bit = I_MASTER_SELECT ? I_MISO : I_MOSI;
   assign sr_shift = I_BIT_ORDER_SELECT ? {in_bit, st_q.sr[7:1]} : {st_q.sr[6:0], in_bit};
   assign done_set = sample && (st_q.bcnt == `SPS_BITS - 4'h1);

   // write acceptance; a slave mid-byte counts as busy
   always_comb
   begin
      if (I_MASTER_SELECT)
         wr_col = I_DATA_WR && st_q.mst == sps_pkg::ST_RUN;
      else
         wr_col = I_DATA_WR && ((!I_CPHA && !I_SS_N) || st_q.bcnt != 4'h0);
      wr_ok = I_DATA_WR && !wr_col && (I_ENABLE || !I_MASTER_SELECT);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   always_comb
   begin
      st_d = st_q;
      st_d.sclk_prev = I_SCLK;
      st_d.irq = 1'b0;
      // master sequencer: half-period timer and edge counter
      case (st_q.mst)
         sps_pkg::ST_IDLE:
         begin
            st_d.sclk = I_CPOL;
            st_d.hcnt = 6'h00;
            st_d.ecnt = 5'h00;
            // an aborted master byte must not leave busy stuck
            if (I_MASTER_SELECT)
               st_d.bcnt = 4'h0;
         end
         sps_pkg::ST_RUN:
         begin
            if (st_q.hcnt == half_len - 6'h01)
            begin
               st_d.hcnt = 6'h00;
               if (st_q.ecnt == `SPS_EDGES)
                  st_d.mst = sps_pkg::ST_IDLE;
               else
               begin
                  st_d.sclk = !st_q.sclk; // eight pulses = sixteen edges
                  st_d.ecnt = st_q.ecnt + 5'h01;
               end
            end
            else
               st_d.hcnt = st_q.hcnt + 6'h01;
            // disabling or leaving master mode aborts the clock
            if (!I_MASTER_SELECT || !I_ENABLE)
               st_d.mst = sps_pkg::ST_IDLE;
         end
         default: st_d.mst = sps_pkg::ST_IDLE;
      endcase
      // deselect restarts the byte and re-presents its first bit
      if (!I_MASTER_SELECT && I_SS_N)
      begin
         st_d.bcnt = 4'h0;
         st_d.mosi = I_BIT_ORDER_SELECT ? st_q.sr[0] : st_q.sr[7];
      end
      // next outgoing bit, also the first bit for phase one
      if (shift_out)
         st_d.mosi = I_BIT_ORDER_SELECT ? st_q.sr[0] : st_q.sr[7];
      if (sample)
      begin
         st_d.sr = sr_shift;
         st_d.bcnt = done_set ? 4'h0 : st_q.bcnt + 4'h1;
      end
      // load: first bit goes out at once, half period before the clock
      if (wr_ok)
      begin
         st_d.sr = I_DATA_WDATA;
         st_d.mosi = I_BIT_ORDER_SELECT ? I_DATA_WDATA[0] : I_DATA_WDATA[7];
         if (I_MASTER_SELECT)
            st_d.mst = sps_pkg::ST_RUN;
      end
      // flag clear: status read arms, next data access clears
      if (I_STATUS_RD)
         st_d.arm = 1'b1;
      if ((I_DATA_RD || I_DATA_WR) && st_q.arm)
      begin
         st_d.arm = 1'b0;
         st_d.done = 1'b0;
         st_d.write_collision_flag = 1'b0;
         st_d.ovf = 1'b0;
      end
      else if (I_DATA_RD || I_DATA_WR)
         st_d.arm = 1'b0;
      // sets come after clears so an event in the clear cycle wins
      if (wr_col)
         st_d.write_collision_flag = 1'b1;
      if (done_set)
      begin
         st_d.rx = sr_shift; // unread byte overwritten
         st_d.done = 1'b1;
         st_d.irq = !st_q.done;
         if (!I_MASTER_SELECT && st_q.done)
            st_d.ovf = 1'b1;
      end
      // overrun has no meaning as master and reads zero
      if (I_MASTER_SELECT)
         st_d.ovf = 1'b0;
      st_d.sclk_oe = I_ENABLE && I_MASTER_SELECT;
      st_d.mosi_oe = I_ENABLE && I_MASTER_SELECT;
      st_d.miso_oe = I_ENABLE && !I_MASTER_SELECT;
      st_d.busy = (st_d.mst == sps_pkg::ST_RUN) || (st_d.bcnt != 4'h0);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         st_q <= '0;
         st_q.mst <= sps_pkg::ST_IDLE;
         st_q.rx <= `SPS_DATA_RST;
      end
      else
         st_q <= st_d;
   end

   // outputs are flip-flop fields
   assign O_DATA_RDATA = st_q.rx;
   assign O_TRANSFER_DONE_FLAG = st_q.done;
   assign O_WRITE_COLLISION_FLAG = st_q.write_collision_flag;
   assign O_RECEIVE_OVERRUN_FLAG = st_q.ovf;
   assign O_SERIAL_DONE_IRQ = st_q.irq;
   assign O_BUSY = st_q.busy;
   assign O_SCLK = st_q.sclk;
   assign O_SCLK_OE = st_q.sclk_oe;
   assign O_MOSI = st_q.mosi;
   assign O_MOSI_OE = st_q.mosi_oe;
   // one data flop serves both roles; only one output is enabled
   assign O_MISO = st_q.mosi;
   assign O_MISO_OE = st_q.miso_oe;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------

   property p_ss_ignore;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (!I_MASTER_SELECT && I_SS_N && !I_DATA_WR) |=> (st_q.bcnt == 4'h0) && $stable(st_q.sr);
   endproperty
   a_ss_ignore: assert property (p_ss_ignore) else $error("slave shifted while deselected");

   property p_master_start;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (I_MASTER_SELECT && I_ENABLE && I_DATA_WR && st_q.mst == sps_pkg::ST_IDLE)
         |=> st_q.mst == sps_pkg::ST_RUN && O_BUSY;
   endproperty
   a_master_start: assert property (p_master_start) else $error("master write did not start transfer");

   property p_first_bit;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (I_MASTER_SELECT && I_ENABLE && I_DATA_WR && st_q.mst == sps_pkg::ST_IDLE && !I_BIT_ORDER_SELECT)
         |=> O_MOSI == $past(I_DATA_WDATA[7]) && O_SCLK == $past(I_CPOL);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first bit not presented before clock");

   property p_sclk_idle;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      ($past(st_q.mst) == sps_pkg::ST_IDLE && st_q.mst == sps_pkg::ST_IDLE && $stable(I_CPOL))
         |-> O_SCLK == I_CPOL;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock not idle");

   property p_edge_bound;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      st_q.ecnt <= `SPS_EDGES;
   endproperty
   a_edge_bound: assert property (p_edge_bound) else $error("more than eight clock pulses");

   property p_miso_oe;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      O_MISO_OE |-> $past(I_ENABLE) && !$past(I_MASTER_SELECT);
   endproperty
   a_miso_oe: assert property (p_miso_oe) else $error("slave out driven while disabled");

   property p_write_collision_flag;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (I_DATA_WR && st_q.mst == sps_pkg::ST_RUN && I_MASTER_SELECT && I_ENABLE)
         |=> O_WRITE_COLLISION_FLAG && (st_q.mst == sps_pkg::ST_RUN || $past(st_q.ecnt) == `SPS_EDGES);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("write during transfer not flagged");

   property p_slave_block;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (!I_MASTER_SELECT && !I_CPHA && !I_SS_N && I_DATA_WR && !sample)
         |=> O_WRITE_COLLISION_FLAG && $stable(st_q.sr);
   endproperty
   a_slave_block: assert property (p_slave_block) else $error("selected slave accepted write");

   property p_irq;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      O_SERIAL_DONE_IRQ == ($rose(O_TRANSFER_DONE_FLAG));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not tied to done flag rising");

   property p_ovf;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (!I_MASTER_SELECT && done_set && st_q.done) |=> O_RECEIVE_OVERRUN_FLAG && O_DATA_RDATA == $past(sr_shift);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overrun not flagged");

   property p_done_set;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      done_set |=> O_TRANSFER_DONE_FLAG && O_DATA_RDATA == $past(sr_shift);
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag or received byte missing");

   property p_slave_accept;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      (!I_MASTER_SELECT && I_CPHA && I_DATA_WR && st_q.bcnt == 4'h0)
         |=> st_q.sr == $past(I_DATA_WDATA);
   endproperty
   a_slave_accept: assert property (p_slave_accept) else $error("idle phase one slave refused write");

   property p_ovf_master;
      @(posedge I_SYS_CLK) disable iff (!I_RESETN)
      I_MASTER_SELECT |=> !O_RECEIVE_OVERRUN_FLAG;
   endproperty
   a_ovf_master: assert property (p_ovf_master) else $error("overrun shown in master mode");

endmodule
`default_nettype wire

// File: testbench/sps_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// far side slave for master runs
// ------------------------------
module sps_partner
(
   // serial pins
   input wire logic i_sclk,
   input wire logic i_mosi,
   output logic o_miso,
   // format and byte
   input wire logic i_cpha,
   input wire logic i_lsb,
   input wire logic i_load,
   input wire logic [7:0] i_tx,
   output logic [7:0] o_rx
);
   int e;
   int k;
   // follows the clock it is given, never sets a rate of its own
   always @(posedge i_load, i_sclk)
   begin
      if (i_load)
         e = 0;
      else
      begin
         e = e + 1;
         if ((e % 2) == (i_cpha ? 0 : 1))
            o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      end
   end
   // bit moves on shift edges; past the byte the line toggles, not holds
   always_comb
   begin
      k = i_cpha ? ((e == 0) ? 0 : (e - 1) / 2) : e / 2;
      o_miso = (k > 7) ? e[0] : i_tx[i_lsb ? k : 7 - k];
   end
endmodule
`default_nettype wire

// File: testbench/sps_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// bench, acting as master in slave runs
// ------------------------------
module sps_port_tb;
   logic clk, rst_n, en, mst, cpol, cpha, lsb, wr, rd, st, bsck, bmo, ss_n, ld;
   logic [1:0] rate;
   logic [7:0] wd, ptx, prx, rdat;
   logic sck, sck_oe, mo, mo_oe, mi, mi_oe, pmi, done, write_collision_flag, ovf, irq, busy;
   logic ps = 1'b0;
   wire logic wsck, wmo, wmi;
   int fail_count = 0;
   int check_count = 0;
   int tog, gap, badg, irqs;
   // pin levels from whoever drives
   assign wsck = sck_oe ? sck : bsck;
   assign wmo = mo_oe ? mo : bmo;
   assign wmi = mi_oe ? mi : pmi;
   sps_port dut (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_ENABLE(en), .I_MASTER_SELECT(mst), .I_CPOL(cpol),
      .I_CPHA(cpha), .I_BIT_ORDER_SELECT(lsb), .I_RATE_DIVIDER_SELECT(rate), .I_DATA_WR(wr), .I_DATA_WDATA(wd),
      .I_DATA_RD(rd), .I_STATUS_RD(st), .O_DATA_RDATA(rdat), .O_TRANSFER_DONE_FLAG(done),
      .O_WRITE_COLLISION_FLAG(write_collision_flag), .O_RECEIVE_OVERRUN_FLAG(ovf), .O_SERIAL_DONE_IRQ(irq), .O_BUSY(busy),
      .I_SCLK(wsck), .O_SCLK(sck), .O_SCLK_OE(sck_oe), .I_MOSI(wmo), .O_MOSI(mo), .O_MOSI_OE(mo_oe),
      .I_MISO(wmi), .O_MISO(mi), .O_MISO_OE(mi_oe), .I_SS_N(ss_n));
   sps_partner prt (.i_sclk(wsck), .i_mosi(wmo), .o_miso(pmi), .i_cpha(cpha), .i_lsb(lsb), .i_load(ld),
      .i_tx(ptx), .o_rx(prx));
   // clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // irq and clock spacing, looked at once outputs settle
   always @(negedge clk)
   begin
      if (irq === 1'b1)
         irqs++;
      gap++;
      if (busy === 1'b1 && sck !== ps)
      begin
         if (tog > 0 && gap != ((rate == 2'h3) ? 32 : (2 << rate)))
            badg++;
         tog++;
         gap = 0;
      end
      ps = sck;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (e !== g)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one-cycle strobe: 0 data write, 1 data read, 2 status read
   task automatic pul(input int w);
      @(negedge clk);
      {wr, rd, st} = {w == 0, w == 1, w == 2};
      @(negedge clk);
      {wr, rd, st} = 3'h0;
      @(negedge clk);
   endtask
   task automatic clr;
      pul(2);
      pul(1);
      chk("flags", 8'h0, {done, write_collision_flag, ovf});
   endtask
   task automatic hp(input logic v);
      repeat (4) @(negedge clk);
      bsck = v;
   endtask
   // bench as master; half period of four clocks keeps the slave's sampling safe
   task automatic sx(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 0; i < 8; i++)
      begin
         // phase one moves data on the leading edge, never before the trailing sample
         if (!cpha)
            bmo = tx[lsb ? i : 7 - i];
         hp(~cpol);
         if (cpha)
            bmo = tx[lsb ? i : 7 - i];
         else
            rx[lsb ? i : 7 - i] = wmi;
         hp(cpol);
         if (cpha)
            rx[lsb ? i : 7 - i] = wmi;
      end
      hp(cpol);
   endtask
   task automatic mx(input logic [3:0] md, input logic c);
      logic [7:0] tx;
      tx = 8'($urandom);
      @(negedge clk);
      {rate, cpha, cpol} = md;
      lsb = 1'($urandom);
      ptx = 8'($urandom);
      ld = 1'b1;
      @(negedge clk);
      {ld, tog, badg, irqs} = '0;
      wd = tx;
      pul(0);
      if (c)
      begin
         wd = ~tx;
         pul(0);
         chk("master write_collision_flag", 8'h1, write_collision_flag);
      end
      for (int i = 0; i < 800 && busy !== 1'b0; i++) @(negedge clk);
      chk("busy", 8'h0, busy);
      chk("mosi byte", tx, prx);
      chk("received", ptx, rdat);
      chk("toggles", 8'h10, tog[7:0]);
      chk("bad gaps", 8'h0, badg[7:0]);
      chk("irqs", 8'h1, irqs[7:0]);
      chk("done", 8'h1, done);
      chk("idle clk", cpol, sck);
      pul(1);
      chk("done kept", 8'h1, done);
      clr();
   endtask
   task automatic sv(input logic [1:0] md);
      logic [7:0] d, m, x, r;
      d = 8'($urandom);
      m = 8'($urandom);
      x = 8'($urandom);
      @(negedge clk);
      {cpha, cpol} = md;
      {lsb, bsck, ss_n, wd} = {1'($urandom), md[0], 1'b1, d};
      pul(0);
      ss_n = 1'b0;
      sx(m, r);
      chk("miso byte", d, r);
      chk("slave rx", m, rdat);
      chk("slave done", 8'h1, done);
      wd = x;
      pul(0);
      chk("slave write_collision_flag", !cpha, write_collision_flag);
      sx(d, r);
      chk("miso next", cpha ? x : m, r);
      chk("overrun", 8'h1, ovf);
      chk("overwrite", d, rdat);
      ss_n = 1'b1;
      clr();
      sx(m, r);
      chk("ignored", d, rdat);
      chk("ignored done", 8'h0, done);
      ss_n = 1'b0;
      hp(~cpol);
      hp(cpol);
      @(negedge clk);
      chk("partial busy", 8'h1, busy);
      ss_n = 1'b1;
      hp(cpol);
      chk("deselect busy", 8'h0, busy);
      ss_n = 1'b0;
      sx(x, r);
      chk("fresh byte", x, rdat);
      ss_n = 1'b1;
      clr();
   endtask
   // main sequence
   initial
   begin
      {rst_n, mst, cpol, cpha, lsb, wr, rd, st, bsck, bmo, ld, rate, wd, ptx} = '0;
      {en, ss_n} = 2'h3;
      void'($urandom(32'h009f19bd));
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      mst = 1'b1;
      for (int i = 0; i < 16; i++) mx(i[3:0], i == 5);
      mst = 1'b0;
      for (int i = 0; i < 4; i++) sv(i[1:0]);
      chk("miso oe on", 8'h1, mi_oe);
      en = 1'b0;
      repeat (2) @(negedge clk);
      chk("miso oe off", 8'h0, mi_oe);
      print_verdict();
   end
   // hang guard, several times the expected run
   initial
   begin
      #200000;
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
